// [core/lsd_pkg.sv]
// shared constants and types of the led string dimming supervisor
package lsd_pkg;

    localparam int          NSTR          = 8;
    localparam int          DUTY_W        = 8;
    localparam int          FBK_W         = 8;
    localparam int          CLK_MHZ       = 100;
    localparam int          CLK_NS        = 10;
    localparam int          OCP_US        = 128;
    localparam int          OCP_CYC       = OCP_US * CLK_MHZ;
    localparam int          MIN_ON_NS     = 90;
    localparam int          MIN_ON_CYC    = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int          F_LOW_KHZ     = 500;
    localparam int          F_MID_KHZ     = 750;
    localparam int          F_HIGH_KHZ    = 1000;
    localparam int          PER_LOW_CYC   = (CLK_MHZ * 1000) / F_LOW_KHZ;
    localparam int          PER_MID_CYC   = (CLK_MHZ * 1000) / F_MID_KHZ;
    localparam int          PER_HIGH_CYC  = (CLK_MHZ * 1000) / F_HIGH_KHZ;
    localparam int          PER_W         = 8;
    localparam int          PWM_SMP_DIV   = 4;
    localparam int          CHOP_DIV      = 16;
    localparam int          STAT_W        = 8;
    localparam int          ST_OCP_BIT    = 2;
    localparam int          ST_OT_BIT     = 3;
    localparam int          ST_OPEN_BIT   = 4;
    localparam int          ST_SHORT_BIT  = 5;
    localparam logic [7:0]  STAT_RST      = 8'h00;
    localparam logic [7:0]  DUTY_RST      = 8'h00;

    typedef enum logic [1:0]
    {
        LSD_DIM_PWM   = 2'b00,
        LSD_DIM_SMB   = 2'b01,
        LSD_DIM_BOTH  = 2'b10,
        LSD_DIM_RSVD  = 2'b11
    } lsd_dim_mode_t;

    typedef enum logic [1:0]
    {
        LSD_F500  = 2'b00,
        LSD_F750  = 2'b01,
        LSD_F1000 = 2'b10
    } lsd_freq_t;

    // raw comparator and pin levels, all asynchronous to core_clk
    typedef struct packed
    {
        logic [NSTR-1:0] open_cmp;
        logic [NSTR-1:0] short_cmp;
        logic            ilim_cmp;
        logic            thermal_cmp;
        logic            peak_cmp;
        logic            skip_cmp;
        logic            sel_vcc;
        logic            sel_gnd;
        logic            pwm_in;
    } lsd_async_t;

    typedef struct packed
    {
        logic [NSTR-1:0] string_enable;
        logic            converter_run;
        logic            switch_on;
        logic            led_chopping_signal;
    } lsd_drive_t;

endpackage : lsd_pkg

// [core/lsd_sync.sv]
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module lsd_sync
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : lsd_sync

// [core/lsd_top.sv]
// led string dimming, fault supervision and converter switch timing
`timescale 1ns/1ps
module lsd_top
    import lsd_pkg::*;
#(
    parameter int OCP_CYCLES = lsd_pkg::OCP_CYC,
    parameter int CHOP_PRESC = lsd_pkg::CHOP_DIV,
    parameter int PWM_PRESC  = lsd_pkg::PWM_SMP_DIV
)
(
    // clock and reset
    input  wire logic                                   core_clk,
    input  wire logic                                   resetn,
    // brightness sources
    input  wire logic                                   brightness_pwm_input,
    input  wire logic [lsd_pkg::DUTY_W-1:0]             smb_brightness,
    input  wire lsd_pkg::lsd_dim_mode_t                 dim_mode,
    input  wire logic                                   ctrl_enable,
    // analog comparators and select pin detectors
    input  wire lsd_pkg::lsd_async_t                    cmp_raw,
    input  wire logic [lsd_pkg::NSTR-1:0]               string_in_use,
    // digitised cathode feedback, same clock
    input  wire logic [lsd_pkg::NSTR*lsd_pkg::FBK_W-1:0] string_cathode_feedback,
    // outputs
    output lsd_pkg::lsd_drive_t                         drive,
    output logic [lsd_pkg::FBK_W-1:0]                   regulation_feedback,
    output logic [lsd_pkg::STAT_W-1:0]                  fault_status,
    output logic [lsd_pkg::DUTY_W-1:0]                  chop_duty
);
    import lsd_pkg::*;

    lsd_async_t cmp;

    lsd_sync #(.W($bits(lsd_async_t))) u_sync
    (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in ({cmp_raw[$bits(lsd_async_t)-1:1], brightness_pwm_input}),
        .sync_out (cmp)
    );

    // enable edge restarts and clears latched faults
    logic en_ff;
    wire  restart = ctrl_enable & ~en_ff;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            en_ff <= 1'b1; // idle level, so leaving reset is no false restart
        else
            en_ff <= ctrl_enable;
    end

    // duty of the pwm input: high samples in a 256-sample window
    logic [7:0]          smp_pre_ff;
    logic [DUTY_W-1:0]   win_cnt_ff;
    logic [DUTY_W:0]     hi_cnt_ff;
    logic [DUTY_W-1:0]   pwm_duty_ff;
    wire                 smp_tick = (smp_pre_ff == 8'(PWM_PRESC - 1));
    wire                 win_end  = smp_tick & (win_cnt_ff == 8'hFF);
    wire [DUTY_W:0]      hi_now   = hi_cnt_ff + {8'h00, cmp.pwm_in};
    wire [DUTY_W-1:0]    nxt_pwm_duty = hi_now[DUTY_W] ? 8'hFF : hi_now[DUTY_W-1:0];

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            smp_pre_ff  <= 8'h00;
            win_cnt_ff  <= 8'h00;
            hi_cnt_ff   <= 9'h000;
            pwm_duty_ff <= DUTY_RST;
        end
        else
        begin
            smp_pre_ff <= smp_tick ? 8'h00 : smp_pre_ff + 8'h01;
            if (smp_tick)
            begin
                win_cnt_ff <= win_cnt_ff + 8'h01;
                hi_cnt_ff  <= win_end ? 9'h000 : hi_now;
            end
            if (win_end)
                pwm_duty_ff <= nxt_pwm_duty;
        end
    end

    // product rounded back to 8 bits
    wire [15:0]       prod     = pwm_duty_ff * smb_brightness + 16'h0080;
    wire [DUTY_W-1:0] nxt_duty = (dim_mode == LSD_DIM_SMB)  ? smb_brightness :
                                 (dim_mode == LSD_DIM_BOTH) ? prod[15:8]     :
                                 pwm_duty_ff;

    // chopping counter; duty is only updated at a cycle start to avoid runt pulses
    logic [7:0]        chop_pre_ff;
    logic [DUTY_W-1:0] chop_cnt_ff;
    logic [DUTY_W-1:0] duty_ff;
    logic              chop_ff;
    wire               chop_tick = (chop_pre_ff == 8'(CHOP_PRESC - 1));

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chop_pre_ff <= 8'h00;
            chop_cnt_ff <= 8'h00;
            duty_ff     <= DUTY_RST;
            chop_ff     <= 1'b0;
        end
        else
        begin
            chop_pre_ff <= chop_tick ? 8'h00 : chop_pre_ff + 8'h01;
            if (chop_tick)
                chop_cnt_ff <= chop_cnt_ff + 8'h01;
            if (chop_tick && chop_cnt_ff == 8'hFF)
                duty_ff <= nxt_duty;
            chop_ff <= ctrl_enable & (chop_cnt_ff < duty_ff);
        end
    end

    // per-string fault latches, held until restart
    logic [NSTR-1:0] open_ff;
    logic [NSTR-1:0] short_ff;
    wire  [NSTR-1:0] live     = string_in_use & ~open_ff & ~short_ff;
    wire  [NSTR-1:0] open_det = live & cmp.open_cmp & {NSTR{chop_ff}};
    wire  [NSTR-1:0] shrt_det = live & cmp.short_cmp & {NSTR{chop_ff}};

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            open_ff  <= '0;
            short_ff <= '0;
        end
        else if (restart)
        begin
            // a fault in the restart cycle still latches, like its status bit
            open_ff  <= open_det;
            short_ff <= shrt_det;
        end
        else
        begin
            open_ff  <= open_ff | open_det;
            short_ff <= short_ff | shrt_det;
        end
    end

    // overcurrent timer and thermal latch
    logic [15:0] ocp_cnt_ff;
    logic        ocp_ff;
    logic        ot_ff;
    wire         ocp_hit = cmp.ilim_cmp & (ocp_cnt_ff == 16'(OCP_CYCLES - 1));

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ocp_cnt_ff <= 16'h0000;
            ocp_ff     <= 1'b0;
            ot_ff      <= 1'b0;
        end
        else
        begin
            ocp_cnt_ff <= (cmp.ilim_cmp && !ocp_ff) ? ocp_cnt_ff + 16'h0001 : 16'h0000;
            ocp_ff     <= ocp_hit | (ocp_ff & ~restart);
            ot_ff      <= cmp.thermal_cmp | (ot_ff & ~restart);
        end
    end

    // run needs enable, no latched overcurrent or thermal fault and at least one live string
    wire run = ctrl_enable & ~ocp_ff & ~ot_ff & (|live);

    // status: set wins over the restart clear
    logic [STAT_W-1:0] stat_ff;
    logic [STAT_W-1:0] nxt_stat;

    always_comb
    begin
        nxt_stat               = restart ? STAT_RST : stat_ff;
        nxt_stat[ST_OPEN_BIT]  = nxt_stat[ST_OPEN_BIT] | (|open_det);
        nxt_stat[ST_SHORT_BIT] = nxt_stat[ST_SHORT_BIT] | (|shrt_det);
        nxt_stat[ST_OCP_BIT]   = nxt_stat[ST_OCP_BIT] | ocp_hit;
        nxt_stat[ST_OT_BIT]    = nxt_stat[ST_OT_BIT] | cmp.thermal_cmp;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            stat_ff <= STAT_RST;
        else
            stat_ff <= nxt_stat;
    end

    // lowest feedback among live strings; dead strings read as full scale
    function automatic logic [FBK_W-1:0] lsd_min(input logic [FBK_W-1:0] a,
                                                 input logic [FBK_W-1:0] b);
        lsd_min = (a < b) ? a : b;
    endfunction : lsd_min

    logic [FBK_W-1:0] min_chain [NSTR:0];
    logic [FBK_W-1:0] reg_min_ff;
    assign min_chain[0] = 8'hFF;

    generate
        for (genvar i = 0; i < NSTR; i++)
        begin : g_min
            wire [FBK_W-1:0] cath_i = live[i] ? string_cathode_feedback[i*FBK_W +: FBK_W] : 8'hFF;
            assign min_chain[i+1] = lsd_min(min_chain[i], cath_i);
        end
    endgenerate

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reg_min_ff <= 8'hFF;
        else
            reg_min_ff <= min_chain[NSTR];
    end

    // tri-level select: vcc detector wins, else gnd, else floating
    wire lsd_freq_t fsel = cmp.sel_vcc ? LSD_F1000 :
                           cmp.sel_gnd ? LSD_F500  : LSD_F750;
    wire [PER_W-1:0] per_cyc = (fsel == LSD_F1000) ? PER_W'(PER_HIGH_CYC) :
                               (fsel == LSD_F500)  ? PER_W'(PER_LOW_CYC)  :
                               PER_W'(PER_MID_CYC);

    // switch timing; skip pulses are fixed minimum width
    logic [PER_W-1:0] per_cnt_ff;
    logic [PER_W-1:0] on_cnt_ff;
    logic             sw_ff;
    logic             skip_ff;
    wire              per_start = (per_cnt_ff >= per_cyc - 8'h01);
    wire              min_done  = (on_cnt_ff >= PER_W'(MIN_ON_CYC - 1));
    wire              sw_end    = skip_ff ? min_done : (min_done & cmp.peak_cmp);
    wire              max_on    = (per_cnt_ff >= per_cyc - 8'h05);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            per_cnt_ff <= 8'h00;
            on_cnt_ff  <= 8'h00;
            sw_ff      <= 1'b0;
            skip_ff    <= 1'b0;
        end
        else
        begin
            per_cnt_ff <= per_start ? 8'h00 : per_cnt_ff + 8'h01;
            if (per_start)
            begin
                skip_ff   <= cmp.skip_cmp;
                sw_ff     <= run;
                on_cnt_ff <= 8'h00;
            end
            else if (sw_ff)
            begin
                on_cnt_ff <= on_cnt_ff + 8'h01;
                sw_ff     <= run & ~sw_end & ~max_on;
            end
        end
    end

    assign drive.string_enable       = live & {NSTR{run}};
    assign drive.converter_run       = run;
    assign drive.switch_on           = sw_ff;
    assign drive.led_chopping_signal = chop_ff;
    assign regulation_feedback       = reg_min_ff;
    assign fault_status              = stat_ff;
    assign chop_duty                 = duty_ff;

endmodule : lsd_top

// [test/lsd_pwm_source.sv]
// pwm brightness source on the host side
`timescale 1ns/1ps
module lsd_pwm_source
(
    // clock
    input  wire logic       core_clk,
    // duty to produce
    input  wire logic [7:0] duty,
    // pin
    output logic            pwm
);
    logic [7:0] cnt_ff;
    initial cnt_ff = 8'h00;
    initial pwm = 1'b0;
    // 256-tick period, so any 256-sample window counts duty exactly
    always @(posedge core_clk)
    begin
        cnt_ff <= cnt_ff + 8'h01;
        pwm    <= (cnt_ff < duty);
    end
endmodule : lsd_pwm_source

// [test/lsd_top_assertions.sv]
// port checks of the led string dimming supervisor
`timescale 1ns/1ps
module lsd_checker
    import lsd_pkg::*;
#(
    parameter int OCP_CYCLES = lsd_pkg::OCP_CYC
)
(
    // clock and reset
    input wire logic                core_clk,
    input wire logic                resetn,
    // inputs watched
    input wire logic                ctrl_enable,
    input wire lsd_pkg::lsd_async_t cmp_raw,
    input wire logic [7:0]          string_in_use,
    input wire logic [63:0]         string_cathode_feedback,
    // outputs watched
    input wire lsd_pkg::lsd_drive_t drive,
    input wire logic [7:0]          regulation_feedback,
    input wire logic [7:0]          fault_status,
    input wire logic [7:0]          chop_duty
);
    logic [15:0] ilim_ff;
    logic [15:0] gap_ff;
    logic        gap_ok_ff;
    logic        sw_ff;
    logic [7:0]  min_en;
    int          per;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    always_comb
    begin
        min_en = 8'hFF;
        for (int i = 0; i < NSTR; i++)
            if (drive.string_enable[i] && string_cathode_feedback[8*i+:8] < min_en)
                min_en = string_cathode_feedback[8*i+:8];
    end
    assign per = cmp_raw.sel_vcc ? PER_HIGH_CYC : (cmp_raw.sel_gnd ? PER_LOW_CYC : PER_MID_CYC);
    // gap between switch turn-ons, only trusted across a continuous run
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ilim_ff   <= 16'h0000;
            gap_ff    <= 16'h0000;
            gap_ok_ff <= 1'b0;
            sw_ff     <= 1'b0;
        end
        else
        begin
            ilim_ff   <= cmp_raw.ilim_cmp ? ilim_ff + 16'h0001 : 16'h0000;
            gap_ff    <= (drive.switch_on && !sw_ff) ? 16'h0001 : gap_ff + 16'h0001;
            gap_ok_ff <= drive.converter_run && (gap_ok_ff || (drive.switch_on && !sw_ff));
            sw_ff     <= drive.switch_on;
        end
    end
    sequence s_hot;
        cmp_raw.thermal_cmp[*4];
    endsequence
    sequence s_off;
        !ctrl_enable ##1 !ctrl_enable;
    endsequence
    property p_min_on;
        $rose(drive.switch_on) |-> ##1 (drive.switch_on || !drive.converter_run)[*8];
    endproperty
    property p_period;
        $rose(drive.switch_on) && gap_ok_ff |-> (gap_ff % per) == 0;
    endproperty
    property p_ocp;
        ilim_ff > OCP_CYCLES + 6 |-> !drive.converter_run && fault_status[ST_OCP_BIT];
    endproperty
    property p_hot;
        s_hot |=> fault_status[ST_OT_BIT] && !drive.converter_run;
    endproperty
    property p_off;
        s_off |-> !drive.converter_run && drive.string_enable == 8'h00;
    endproperty
    property p_in_use;
        (drive.string_enable & ~string_in_use) == 8'h00;
    endproperty
    property p_open;
        $rose(fault_status[ST_OPEN_BIT]) |->
            $countones(drive.string_enable) < $countones($past(drive.string_enable));
    endproperty
    property p_short;
        $rose(fault_status[ST_SHORT_BIT]) |->
            $countones(drive.string_enable) < $countones($past(drive.string_enable));
    endproperty
    property p_regfb;
        // first edge out of reset still sees the flop held in reset
        $past(resetn) && drive.converter_run && $stable(drive.string_enable) |=>
            regulation_feedback == $past(min_en);
    endproperty
    property p_duty_stands;
        $changed(chop_duty) |=> $stable(chop_duty)[*8];
    endproperty
    a_min_on: assert property (p_min_on) else $error("switch pulse too short");
    a_period: assert property (p_period) else $error("switch period wrong");
    a_ocp: assert property (p_ocp) else $error("current limit not latched");
    a_hot: assert property (p_hot) else $error("thermal not latched");
    a_off: assert property (p_off) else $error("shutdown ignored");
    a_in_use: assert property (p_in_use) else $error("unused string on");
    a_open: assert property (p_open) else $error("open without disable");
    a_short: assert property (p_short) else $error("short without disable");
    a_regfb: assert property (p_regfb) else $error("regulation min wrong");
    a_duty_stands: assert property (p_duty_stands) else $error("duty unstable");
endmodule : lsd_checker

bind lsd_top lsd_checker #(.OCP_CYCLES(OCP_CYCLES)) u_chk
(
    .core_clk(core_clk),
    .resetn(resetn),
    .ctrl_enable(ctrl_enable),
    .cmp_raw(cmp_raw),
    .string_in_use(string_in_use),
    .string_cathode_feedback(string_cathode_feedback),
    .drive(drive),
    .regulation_feedback(regulation_feedback),
    .fault_status(fault_status),
    .chop_duty(chop_duty)
);

// [test/lsd_top_test.sv]
// self-checking bench of the led string dimming supervisor
`timescale 1ns/1ps
module lsd_top_test;
    import lsd_pkg::*;
    logic          core_clk;
    logic          resetn;
    logic          pwm;
    logic [7:0]    pwm_duty;
    logic [7:0]    smb;
    lsd_dim_mode_t mode;
    logic          ctrl_enable;
    lsd_async_t    cmp;
    lsd_drive_t    drive;
    logic [7:0]    regfb;
    logic [7:0]    status;
    logic [7:0]    duty;
    logic [7:0]    in_use;
    int            failures;
    int            comparisons;
    lsd_pwm_source src (.core_clk(core_clk), .duty(pwm_duty), .pwm(pwm));
    lsd_top #(.OCP_CYCLES(64), .CHOP_PRESC(1), .PWM_PRESC(1)) uut
    (
        .core_clk(core_clk), .resetn(resetn), .brightness_pwm_input(pwm),
        .smb_brightness(smb), .dim_mode(mode), .ctrl_enable(ctrl_enable),
        .cmp_raw(cmp), .string_in_use(in_use),
        .string_cathode_feedback(64'h7870_6860_5810_4840), .drive(drive),
        .regulation_feedback(regfb), .fault_status(status), .chop_duty(duty)
    );
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // host side: control bit 0 cleared, then set again
    task automatic restart(logic [7:0] exp_stat);
        tick(1);
        ctrl_enable <= 1'b0;
        tick(4);
        @(negedge core_clk);
        check("run", drive.converter_run, 0);
        tick(1);
        ctrl_enable <= 1'b1;
        tick(6);
        @(negedge core_clk);
        check("status", status, exp_stat);
    endtask : restart
    task automatic t_dim(lsd_dim_mode_t m, logic [7:0] p, logic [7:0] s, logic [7:0] e);
        int hi;
        hi = 0;
        tick(1);
        mode <= m;
        pwm_duty <= p;
        smb <= s;
        tick(1100);
        repeat (256) @(negedge core_clk) hi += drive.led_chopping_signal;
        check("chop_duty", duty, e);
        check("chop high", hi, e);
        $display("dimming mode %0d done", m);
    endtask : t_dim
    task automatic t_fault();
        check("min", regfb, 8'h10);
        tick(1);
        cmp.open_cmp[2] <= 1'b1;
        tick(600);
        @(negedge core_clk);
        check("enables", drive.string_enable, 8'hFB);
        check("status", status, 8'h10);
        check("min", regfb, 8'h40);
        tick(1);
        cmp.short_cmp[5] <= 1'b1;
        tick(600);
        @(negedge core_clk);
        check("enables", drive.string_enable, 8'hDB);
        check("status", status, 8'h30);
        tick(1);
        cmp.open_cmp[2] <= 1'b0;
        cmp.short_cmp[5] <= 1'b0;
        restart(8'h00);
        check("enables", drive.string_enable, 8'hFF);
        // a string not fitted is never driven nor regulated on
        tick(1);
        in_use <= 8'hFB;
        tick(2);
        @(negedge core_clk);
        check("enables", drive.string_enable, 8'hFB);
        check("min", regfb, 8'h40);
        tick(1);
        in_use <= 8'hFF;
        $display("string faults done");
    endtask : t_fault
    task automatic t_trip();
        // two bursts just under the limit must not add up
        repeat (2)
        begin
            tick(1);
            cmp.ilim_cmp <= 1'b1;
            tick(56);
            cmp.ilim_cmp <= 1'b0;
            tick(4);
        end
        @(negedge core_clk);
        check("status", status, 0);
        tick(1);
        cmp.ilim_cmp <= 1'b1;
        tick(72);
        @(negedge core_clk);
        check("status", status, 8'h04);
        check("run", drive.converter_run, 0);
        tick(1);
        cmp.ilim_cmp <= 1'b0;
        cmp.thermal_cmp <= 1'b1;
        restart(8'h08);
        check("status", status, 8'h08);
        check("run", drive.converter_run, 0);
        tick(1);
        cmp.thermal_cmp <= 1'b0;
        restart(8'h00);
        $display("shutdown faults done");
    endtask : t_trip
    task automatic t_freq(logic v, logic g, logic s, logic k, int per, int on_exp);
        int r[$];
        int on;
        logic was;
        on = 0;
        was = 1'b0;
        tick(1);
        ctrl_enable <= 1'b0;
        cmp.sel_vcc <= v;
        cmp.sel_gnd <= g;
        cmp.skip_cmp <= s;
        cmp.peak_cmp <= k;
        tick(6);
        ctrl_enable <= 1'b1;
        for (int i = 0; i < 1000; i++)
        begin
            @(negedge core_clk);
            if (drive.switch_on === 1'b1 && !was)
                r.push_back(i);
            if (r.size() == 2)
                on += drive.switch_on;
            was = drive.switch_on;
        end
        check("period", r[2] - r[1], per);
        check("on time", on, on_exp);
        $display("switching %0d done", per);
    endtask : t_freq
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #400000;
        failures++;
        complete_run();
    end
    initial
    begin
        failures = 0;
        comparisons = 0;
        resetn = 1'b0;
        pwm_duty = 8'h80;
        smb = 8'h80;
        mode = LSD_DIM_SMB;
        ctrl_enable = 1'b1;
        cmp = '0;
        in_use = 8'hFF;
        tick(16);
        resetn <= 1'b1;
        t_dim(LSD_DIM_PWM, 8'h40, 8'h80, 8'h40);
        t_dim(LSD_DIM_SMB, 8'h40, 8'h80, 8'h80);
        t_dim(LSD_DIM_BOTH, 8'h40, 8'h80, 8'h20);
        t_dim(LSD_DIM_BOTH, 8'hFF, 8'hFF, 8'hFE);
        t_dim(LSD_DIM_RSVD, 8'h33, 8'h80, 8'h33);
        t_fault();
        t_trip();
        t_freq(1'b1, 1'b0, 1'b0, 1'b0, PER_HIGH_CYC, PER_HIGH_CYC - 4);
        t_freq(1'b0, 1'b1, 1'b0, 1'b0, PER_LOW_CYC, PER_LOW_CYC - 4);
        t_freq(1'b0, 1'b0, 1'b0, 1'b0, PER_MID_CYC, PER_MID_CYC - 4);
        t_freq(1'b1, 1'b0, 1'b1, 1'b0, PER_HIGH_CYC, MIN_ON_CYC);
        t_freq(1'b0, 1'b1, 1'b0, 1'b1, PER_LOW_CYC, MIN_ON_CYC);
        complete_run();
    end
endmodule : lsd_top_test
